// ### common/pie_consts.vh
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH
// Register addresses in the register file
`define PIE_ADDR_PA_EN_HIGH  12'hFC4
`define PIE_ADDR_PA_EN_LOW   12'hFC5
`define PIE_ADDR_PC_EN_HIGH  12'hFC7
`define PIE_ADDR_PC_EN_LOW   12'hFC8
`define PIE_ADDR_SHARED_SEL  12'hFC9
`define PIE_ADDR_PA_EDGE     12'hFCA
// Reset values
`define PIE_RST_ENABLE       8'h00
`define PIE_RST_SEL          8'h00
`define PIE_RST_EDGE         8'h00
// Field positions in the shared source select register
`define PIE_SEL_LVD_BIT      7
`define PIE_SEL_CMP_BIT      6
// Priority levels
`define PIE_LVL_OFF          2'h0
`define PIE_LVL_LOW          2'h1
`define PIE_LVL_MED          2'h2
`define PIE_LVL_HIGH         2'h3
// Port C implemented width
`define PIE_PC_BITS          4
`endif

// ### design/pie_edge_detect.v
`timescale 1ns/1ps
// Per-pin edge detector: rising, falling or both edges
module pie_edge_detect #(
   parameter WIDTH = 8
) (
   input  wire             CORE_CLK,
   input  wire             RESET_N,
   input  wire [WIDTH-1:0] PIN_IN,
   input  wire [WIDTH-1:0] FALL_SEL,
   input  wire             BOTH_EDGES,
   output wire [WIDTH-1:0] EDGE_PULSE
);

   reg [WIDTH-1:0] prev_reg;   // Pin level one cycle ago
   reg             armed_reg;  // Low in the first cycle after reset

   // Remember previous pin level
   // Pulses stay masked for one cycle after reset, since a pin already
   // high at release is a level and not an edge
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prev_reg  <= {WIDTH{1'b0}};
         armed_reg <= 1'b0;
      end else begin
         prev_reg  <= PIN_IN;
         armed_reg <= 1'b1;
      end
   end

   // Rise, fall or either; combinational so the pulse lines up with the change
   // Limitation: a real edge inside that first masked cycle is lost
   assign EDGE_PULSE = {WIDTH{armed_reg}} &
                       (BOTH_EDGES ? (PIN_IN ^ prev_reg) :
                        ((PIN_IN & ~prev_reg & ~FALL_SEL) | (~PIN_IN & prev_reg & FALL_SEL)));

endmodule // pie_edge_detect

// ### design/pie_port_irq.v
`timescale 1ns/1ps
`include "pie_consts.vh"
// Summary of operation
// - Enable pair encodes off, low, medium, high
// - Port A high and low enable registers
// - Bit 7 pair governs pin7 or detector
// - Bit 6 pair governs pin6 or comparator
// - Select chooses pin or shared source
// - Port C high enables in bits 3:0
// - Port A selectable edge, port C both
// - Equal level resolved by fixed vector order
module pie_port_irq #(
   parameter ADDR_W = 12
) (
   input  wire              CORE_CLK,
   input  wire              RESET_N,
   input  wire [ADDR_W-1:0] ADDR,
   input  wire [7:0]        WDATA,
   input  wire              WR,
   input  wire              RD,
   output reg  [7:0]        RDATA,
   input  wire [7:0]        PORTA_IN,
   input  wire [3:0]        PORTC_IN,
   input  wire              LVD_IRQ,
   input  wire              CMP_IRQ,
   input  wire              IRQ_ACK,
   output wire              IRQ_REQ,
   output reg  [1:0]        IRQ_LEVEL,
   output reg  [3:0]        IRQ_SRC
);

   // Register map on the register file bus:
   //   port A high enables, one bit per pin
   //   port A low enables, one bit per pin
   //   port C high enables in the low nibble
   //   port C low enables in the low nibble
   //   shared source select, bit 7 detector, bit 6 comparator
   //   port A edge polarity, one bit per pin
   // Source numbering, highest first:
   //   11 down to 4 are port A pins 7 down to 0
   //   3 down to 0 are port C pins 3 down to 0
   // Pending flags latch even for disabled sources. Limitation: a flag
   // caught while its pair was off surfaces as soon as software
   // programs the pair, so the core sees an old event then.

   // Enable and control registers
   reg [7:0] pa_en_high_reg;   // Port A high enables
   reg [7:0] pa_en_low_reg;    // Port A low enables
   reg [7:0] pc_en_high_reg;   // Port C high enables, upper nibble stored
   reg [3:0] pc_en_low_reg;    // Port C low enables
   reg [7:0] shared_sel_reg;   // Shared source select
   reg [7:0] pa_edge_reg;      // Port A edge polarity, 1 = falling
   reg [11:0] pending_reg;     // Pending requests, index 11 = port A pin 7
   reg [11:0] pending_next;    // Next pending value
   reg [1:0]  best_lvl;        // Winning level
   reg [3:0]  best_idx;        // Winning source index
   reg [1:0]  lvl;             // Scratch level
   integer    i;               // Loop index

   wire [7:0]  pa_edge;        // Port A edge pulses
   wire [3:0]  pc_edge;        // Port C edge pulses
   wire [7:0]  pa_event;       // Port A events after sharing
   wire [11:0] events;         // All events in vector order
   wire [11:0] en_high;        // High enables aligned to events
   wire [11:0] en_low;         // Low enables aligned to events
   wire [11:0] ack_clr;        // Clear from core acknowledge

   // Priority level from an enable pair
   function [1:0] pair_level;
      input hi;
      input lo;
      begin
         pair_level = {hi, lo};
      end
   endfunction

   // Port A edges, selectable polarity
   // Polarity per pin comes from the edge register
   pie_edge_detect #(.WIDTH(8)) u_pa_edge (
      .CORE_CLK   (CORE_CLK),
      .RESET_N    (RESET_N),
      .PIN_IN     (PORTA_IN),
      .FALL_SEL   (pa_edge_reg),
      .BOTH_EDGES (1'b0),
      .EDGE_PULSE (pa_edge)
   );

   // Port C edges, both directions
   // Both edges count, so port C needs no polarity register
   pie_edge_detect #(.WIDTH(4)) u_pc_edge (
      .CORE_CLK   (CORE_CLK),
      .RESET_N    (RESET_N),
      .PIN_IN     (PORTC_IN),
      .FALL_SEL   (4'h0),
      .BOTH_EDGES (1'b1),
      .EDGE_PULSE (pc_edge)
   );

   // Shared lines: pin or internal source; internal sources are event pulses
   // Limitation: a held internal level would set its flag again every
   // cycle, so those sources must deliver one-cycle pulses
   assign pa_event[7]   = shared_sel_reg[`PIE_SEL_LVD_BIT] ? LVD_IRQ : pa_edge[7];
   assign pa_event[6]   = shared_sel_reg[`PIE_SEL_CMP_BIT] ? CMP_IRQ : pa_edge[6];
   assign pa_event[5:0] = pa_edge[5:0];

   // Port C below port A so lower index means lower precedence
   assign events  = {pa_event, pc_edge};
   assign en_high = {pa_en_high_reg, pc_en_high_reg[3:0]};
   assign en_low  = {pa_en_low_reg, pc_en_low_reg};

   // Acknowledge clears the current live winning source
   // Hazard: this is the live winner, not the registered source; a core
   // that acks while a newcomer just took over clears the newcomer, so
   // the core lets level and source settle before it acknowledges
   assign ack_clr = (IRQ_ACK && IRQ_REQ) ? (12'h001 << best_idx) : 12'h000;

   // Pending flags: new event beats acknowledge in the same cycle
   // Set wins so an edge landing on the ack cycle is never lost
   always @* begin
      pending_next = (pending_reg & ~ack_clr) | events;
   end

   // Pick highest level, ties to highest index
   // Twelve sources scanned in one cycle; a flat scan is cheap at this size
   always @* begin
      best_lvl = `PIE_LVL_OFF;
      best_idx = 4'h0;
      lvl      = `PIE_LVL_OFF;
      for (i = 0; i < 12; i = i + 1) begin
         lvl = pair_level(en_high[i], en_low[i]);
         // Ascending scan with >= lets the later, higher-index vector win ties
         if (pending_reg[i] && lvl != `PIE_LVL_OFF && lvl >= best_lvl) begin
            best_lvl = lvl;
            best_idx = i[3:0];
         end
      end
   end

   // Request is combinational, one cycle ahead of level and source
   // Traded for a faster request at the cost of a longer path to the core
   assign IRQ_REQ = (best_lvl != `PIE_LVL_OFF);

   // Register writes and pending state
   // Reserved port C high-enable nibble is kept so a readback shows what was written
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pa_en_high_reg <= `PIE_RST_ENABLE;
         pa_en_low_reg  <= `PIE_RST_ENABLE;
         pc_en_high_reg <= `PIE_RST_ENABLE;
         pc_en_low_reg  <= 4'h0;
         shared_sel_reg <= `PIE_RST_SEL;
         pa_edge_reg    <= `PIE_RST_EDGE;
         pending_reg    <= 12'h000;
      end else begin
         pending_reg <= pending_next;
         if (WR) begin
            case (ADDR)
               `PIE_ADDR_PA_EN_HIGH: begin
                  pa_en_high_reg <= WDATA;
               end
               `PIE_ADDR_PA_EN_LOW: begin
                  pa_en_low_reg <= WDATA;
               end
               `PIE_ADDR_PC_EN_HIGH: begin
                  // Upper nibble stored as written; software keeps it zero
                  pc_en_high_reg <= WDATA;
               end
               `PIE_ADDR_PC_EN_LOW: begin
                  pc_en_low_reg <= WDATA[3:0];
               end
               `PIE_ADDR_SHARED_SEL: begin
                  shared_sel_reg <= WDATA;
               end
               `PIE_ADDR_PA_EDGE: begin
                  pa_edge_reg <= WDATA;
               end
               default: begin
                  // Unmapped writes are ignored
               end
            endcase
         end
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   // Zero outside the read cycle keeps a wired read bus quiet
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            `PIE_ADDR_PA_EN_HIGH:  RDATA <= pa_en_high_reg;
            `PIE_ADDR_PA_EN_LOW:   RDATA <= pa_en_low_reg;
            `PIE_ADDR_PC_EN_HIGH:  RDATA <= pc_en_high_reg;
            `PIE_ADDR_PC_EN_LOW:   RDATA <= {4'h0, pc_en_low_reg};
            `PIE_ADDR_SHARED_SEL:  RDATA <= shared_sel_reg;
            `PIE_ADDR_PA_EDGE:     RDATA <= pa_edge_reg;
            default:               RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // Registered winner for the core
   // Level and source lag the request by one cycle
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         IRQ_LEVEL <= `PIE_LVL_OFF;
         IRQ_SRC   <= 4'h0;
      end else begin
         IRQ_LEVEL <= best_lvl;
         IRQ_SRC   <= best_idx;
      end
   end

endmodule // pie_port_irq

// ### tb/pie_checker.sv
`timescale 1ns/1ps
// Port-level checker; shadows enable writes to predict levels
module pie_checker #(
   parameter ADDR_W = 12
) (
   input logic              CORE_CLK,
   input logic              RESET_N,
   input logic [ADDR_W-1:0] ADDR,
   input logic [7:0]        WDATA,
   input logic              WR,
   input logic              RD,
   input logic [7:0]        RDATA,
   input logic [3:0]        PORTC_IN,
   input logic              IRQ_ACK,
   input logic              IRQ_REQ,
   input logic [1:0]        IRQ_LEVEL,
   input logic [3:0]        IRQ_SRC
);
   logic [11:0] en_h, en_l;  // Shadow pairs, index = source number
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // Shadow follows bus writes; select and edge writes ignored
   always @(posedge CORE_CLK or negedge RESET_N)
      if (!RESET_N) {en_h, en_l} <= 24'h000000;
      else if (WR && ADDR == 12'hFC4) en_h[11:4] <= WDATA;
      else if (WR && ADDR == 12'hFC5) en_l[11:4] <= WDATA;
      else if (WR && ADDR == 12'hFC7) en_h[3:0] <= WDATA[3:0];
      else if (WR && ADDR == 12'hFC8) en_l[3:0] <= WDATA[3:0];
   sequence s_wr_rd;
      WR && ADDR inside {12'hFC4, 12'hFC5, 12'hFC7} ##1 RD && !WR && ADDR == $past(ADDR);
   endsequence
   sequence s_pc_edge;
      ((PORTC_IN ^ $past(PORTC_IN)) & (en_h[3:0] | en_l[3:0])) != 4'h0;
   endsequence
   AST_RD_ZERO: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("stray data");
   AST_READBACK: assert property (s_wr_rd |=> RDATA == $past(WDATA, 2))
      else $error("readback differs");
   AST_RST_QUIET: assert property (!$past(RESET_N) |-> !IRQ_REQ) else $error("req at reset");
   AST_OFF_QUIET: assert property ({en_h, en_l} == 24'h0 |-> !IRQ_REQ)
      else $error("req while disabled");
   AST_LVL_IDLE: assert property (!$past(IRQ_REQ) |-> IRQ_LEVEL == 2'h0)
      else $error("level without req");
   AST_LVL_MAP: assert property (IRQ_LEVEL != 2'h0 && $stable({en_h, en_l})
      |-> IRQ_LEVEL == {en_h[IRQ_SRC], en_l[IRQ_SRC]}) else $error("level mismatch");
   AST_PC_EDGE: assert property (s_pc_edge |-> ##[1:2] IRQ_REQ) else $error("edge lost");
   AST_HOLD: assert property (IRQ_REQ && !IRQ_ACK && !WR |=> IRQ_REQ)
      else $error("req dropped");
endmodule // pie_checker

// ### tb/pie_core_model.sv
`timescale 1ns/1ps
// Core side: acks a settled request, logs what it took
module pie_core_model #(
   parameter GAP = 3
) (
   input  logic       clk,
   input  logic       rst_n,
   input  logic       req,
   input  logic [1:0] lvl,
   input  logic [3:0] src,
   output logic       ack,
   output logic [3:0] last_src,
   output logic [1:0] last_lvl,
   output int         acks
);
   int wait_cnt;  // Spacing lets level and source resettle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         wait_cnt <= 0;
         acks <= 0;
      end else begin
         ack <= 1'b0;
         if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
         else if (req && lvl != 2'h0) begin
            ack <= 1'b1;
            wait_cnt <= GAP;
            last_src <= src;
            last_lvl <= lvl;
            acks <= acks + 1;
         end
      end
   end
endmodule // pie_core_model

// ### tb/pie_port_irq_bench.sv
`timescale 1ns/1ps
module pie_port_irq_bench;
   logic        CORE_CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0;
   logic        LVD_IRQ = 1'b0, CMP_IRQ = 1'b0, IRQ_ACK, IRQ_REQ;
   logic [11:0] ADDR = 12'h000;
   logic [7:0]  WDATA = 8'h00, PORTA_IN = 8'h00, RDATA;
   logic [3:0]  PORTC_IN = 4'h0, IRQ_SRC, last_src;
   logic [1:0]  IRQ_LEVEL, last_lvl;
   int          error_cnt = 0, checked = 0, acks;
   logic [5:0]  exp_t [4] = '{6'h2F, 6'h0F, 6'h26, 6'h11};  // {source, level} in ack order
   pie_port_irq DUT (
      .CORE_CLK  (CORE_CLK),
      .RESET_N   (RESET_N),
      .ADDR      (ADDR),
      .WDATA     (WDATA),
      .WR        (WR),
      .RD        (RD),
      .RDATA     (RDATA),
      .PORTA_IN  (PORTA_IN),
      .PORTC_IN  (PORTC_IN),
      .LVD_IRQ   (LVD_IRQ),
      .CMP_IRQ   (CMP_IRQ),
      .IRQ_ACK   (IRQ_ACK),
      .IRQ_REQ   (IRQ_REQ),
      .IRQ_LEVEL (IRQ_LEVEL),
      .IRQ_SRC   (IRQ_SRC)
   );
   pie_core_model core (.clk(CORE_CLK), .rst_n(RESET_N), .req(IRQ_REQ), .lvl(IRQ_LEVEL),
      .src(IRQ_SRC), .ack(IRQ_ACK), .last_src(last_src), .last_lvl(last_lvl), .acks(acks));
   always #10 CORE_CLK = ~CORE_CLK;
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Extra edge keeps back-to-back strobes from double assignment
   task wr(input logic [11:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk("rdata", e, RDATA);
      @(posedge CORE_CLK);
   endtask
   // Write then read back with no idle cycle between the strobes
   task wr_rd(input logic [11:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk("readback", d, RDATA);
      @(posedge CORE_CLK);
   endtask
   // Waits for the core to take one request
   task pend(input logic [3:0] s, input logic [1:0] l);
      int n;
      n = acks;
      repeat (40) if (acks == n) @(posedge CORE_CLK);
      #1 chk("taken", 8'h01, {7'h00, acks != n});
      chk("source", {4'h0, s}, {4'h0, last_src});
      chk("level", {6'h00, l}, {6'h00, last_lvl});
      @(posedge CORE_CLK);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      rd(12'hFC4, 8'h00);
      rd(12'hFC7, 8'h00);
      wr_rd(12'hFC4, 8'hA0);
      wr_rd(12'hFC5, 8'h81);
      wr_rd(12'hFC7, 8'h08);
      wr(12'hFC8, 8'h08);
      rd(12'hFC4, 8'hA0);
      rd(12'hFC5, 8'h81);
      rd(12'hFC7, 8'h08);
      rd(12'hFC6, 8'h00);
      PORTA_IN <= 8'hA1;
      PORTC_IN <= 4'h8;
      foreach (exp_t[i]) pend(exp_t[i][5:2], exp_t[i][1:0]);
      PORTA_IN <= 8'h00;
      PORTC_IN <= 4'h0;
      pend(4'h3, 2'h3);
      wr(12'hFCA, 8'h01);
      PORTA_IN <= 8'h01;
      repeat (3) @(posedge CORE_CLK);
      #1 chk("req", 8'h00, {7'h00, IRQ_REQ});
      PORTA_IN <= 8'h00;
      pend(4'h4, 2'h1);
      wr(12'hFC9, 8'hC0);
      wr(12'hFC4, 8'hE0);
      LVD_IRQ <= 1'b1;
      @(posedge CORE_CLK);
      LVD_IRQ <= 1'b0;
      pend(4'hB, 2'h3);
      CMP_IRQ <= 1'b1;
      @(posedge CORE_CLK);
      CMP_IRQ <= 1'b0;
      pend(4'hA, 2'h2);
      // Reset in mid-run with a port C pin held high across it
      RESET_N <= 1'b0;
      PORTC_IN <= 4'h8;
      repeat (3) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      rd(12'hFC4, 8'h00);
      rd(12'hFC5, 8'h00);
      rd(12'hFC7, 8'h00);
      wr(12'hFC7, 8'h08);
      wr(12'hFC8, 8'h08);
      repeat (2) @(posedge CORE_CLK);
      #1 chk("req", 8'h00, {7'h00, IRQ_REQ});
      @(posedge CORE_CLK);
      PORTC_IN <= 4'h0;
      pend(4'h3, 2'h3);
      report_and_stop;
   end
   // Watchdog against a hung request
   initial begin
      repeat (3000) @(posedge CORE_CLK);
      error_cnt++;
      report_and_stop;
   end
endmodule // pie_port_irq_bench
bind pie_port_irq pie_checker #(
   .ADDR_W (ADDR_W)
) u_chk (
   .CORE_CLK  (CORE_CLK),
   .RESET_N   (RESET_N),
   .ADDR      (ADDR),
   .WDATA     (WDATA),
   .WR        (WR),
   .RD        (RD),
   .RDATA     (RDATA),
   .PORTC_IN  (PORTC_IN),
   .IRQ_ACK   (IRQ_ACK),
   .IRQ_REQ   (IRQ_REQ),
   .IRQ_LEVEL (IRQ_LEVEL),
   .IRQ_SRC   (IRQ_SRC)
);
